// ==== pkg/codec_clk_cfg.svh ====
// Purpose: Constants for the codec clock mode control block.
// Assumes: 125 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef CODEC_CLK_CFG_SVH
`define CODEC_CLK_CFG_SVH

`define CLK_FREQ_HZ        125000000
`define LOCK_FRAME_MS      160
`define LOCK_BIT_MS        4
`define LOCK_MCLK_MS       40
`define LOCK_FRAME_CYC     (`LOCK_FRAME_MS * (`CLK_FREQ_HZ / 1000))
`define LOCK_BIT_CYC       (`LOCK_BIT_MS * (`CLK_FREQ_HZ / 1000))
`define LOCK_MCLK_CYC      (`LOCK_MCLK_MS * (`CLK_FREQ_HZ / 1000))

`define REF_FRAME          4'h0
`define REF_BIT32          4'h2
`define REF_BIT64          4'h3
`define REF_MCLK_LO        4'h4
`define REF_MCLK_13M5      4'hc
`define REF_MCLK_27M       4'hd
`define REF_KIND_BIT       2

`define RATE_RESET         4'h0
`define REF_RESET          4'h0
`define DIV_RESET          2'h0
`define BCLK_RATIO_RESET   1'b0
`define MS_RESET           1'b0

`endif

// ==== pkg/codec_clk_pkg.sv ====
// Purpose: Types for the codec clock mode control block.
// Assumes: Used together with codec_clk_cfg.svh.
// Notes:   States are Gray coded along the normal path.
package codec_clk_pkg;

  typedef enum logic [1:0] {
    MODE_EXTERNAL_SLAVE = 2'h0,
    MODE_PLL_SLAVE   = 2'h1,
    MODE_PLL_MASTER  = 2'h3,
    MODE_UNSUPPORTED = 2'h2
  } clk_mode_type;

  typedef enum logic [1:0] {
    LOCK_OFF     = 2'h0,
    LOCK_WAIT    = 2'h1,
    LOCK_SETTLE  = 2'h3,
    LOCK_DONE    = 2'h2
  } lock_state_type;

  typedef struct packed {
    logic       pll_power_bit;
    logic       master_select;
    logic [3:0] pll_ref_select;
    logic [3:0] rate_select;
    logic [1:0] mclk_out_divider;
    logic       bitclk_ratio_select;
    logic       mclk_out_enable;
  } clk_ctrl_type;

  typedef struct packed {
    logic       ref_valid;
    logic       rate_valid;
    logic [1:0] ext_mclk_ratio;
  } clk_status_type;

endpackage

// ==== rtl/codec_clk_divider.sv ====
// Purpose: Divide the system clock into one-cycle enable pulses.
// Assumes: Single clock domain.
// Notes:   A zero divisor is treated as one so the pulse never stops.
`timescale 1ns/100ps
module codec_clk_divider #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             run_i,
  input  wire logic [WIDTH-1:0] divisor_i,
  output logic                  tick_o
);

  logic [WIDTH-1:0] count;

  // Count down from one below the divisor and pulse at zero; stopped counters restart cleanly.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (count == '0) begin
      count  <= (divisor_i == '0) ? '0 : divisor_i - WIDTH'(1);
      tick_o <= 1'b1;
    end else begin
      count  <= count - WIDTH'(1);
      tick_o <= 1'b0;
    end
  end

endmodule

// ==== rtl/codec_clock_mode_control.sv ====
// Purpose: Clock mode decode, PLL lock tracking and clock pin control for a codec.
// Assumes: Control bits arrive as plain ports synchronous to clock_i; reset is the
//          power-down pin. Generated clocks are modelled as enable-rate toggles.
// Notes:   Bit and frame clock pins are two signals each; enable high drives.
`include "codec_clk_cfg.svh"
`timescale 1ns/100ps

// Behaviour
// - Power and master bits decode into PLL master, PLL slave or external slave.
// - Power clear with master set is unsupported; enabled master clock output invalid.
// - Master select one means master, zero slave; reset default slave.
// - Device leaves reset as slave, becomes master only after host writes one.
// - Bit and frame clock pins stay undriven until master select is one.
// - PLL master drives frame clock at fs, bit clock at chosen ratio.
// - Master clock output enable zero holds master clock output low always.
// - PLL slave takes bit and frame clocks as inputs from outside.
// - Reference select decodes frame, bit or master clock; other codes invalid.
// - Lock within 160ms frame, 4ms bit, 40ms master clock reference.
// - Master clock reference: rate field picks one of twelve sampling rates.
// - Frame or bit reference: rate field ignores bit two, picks a range.
// - PLL master before first lock: bit and frame clocks driven low.
// - After lock the first frame may be irregular, regular after one period.
// - Rate change in master: host clears power so clocks go low.
// - Later unlock in master may leave all outputs invalid; locked frame is fs.
// - PLL slave unlocked: master clock output and converter data invalid.
// - Output divider selects 256, 128, 64 or 32 fs.
// - Ratio bit selects 32 fs when zero, 64 fs when one.
// - External slave: rate bits one-zero select 256, 1024 or 512 fs input.
// - Power-down pin low resets every control register to its initial value.
module codec_clock_mode_control
  import codec_clk_pkg::*;
#(
  parameter int LOCK_FRAME_CYCLES = `LOCK_FRAME_CYC,
  parameter int LOCK_BIT_CYCLES   = `LOCK_BIT_CYC,
  parameter int LOCK_MCLK_CYCLES  = `LOCK_MCLK_CYC,
  parameter int FS_DIV_WIDTH      = 16,
  parameter int FS_DIVISOR        = 1302
) (
  input  wire logic           clock_i,
  input  wire logic           rst_b_i,
  input  wire clk_ctrl_type   ctrl_i,
  output clk_mode_type        clk_mode_o,
  output clk_status_type      status_o,
  output logic                pll_locked_o,
  output logic                clocks_regular_o,
  output logic                data_invalid_o,
  output logic                mclk_out_invalid_o,
  output logic                mclk_in_used_o,
  output logic                mclk_out_o,
  output logic                bit_clock_pin_o,
  output logic                bit_clock_pin_oe_o,
  output logic                frame_clock_pin_o,
  output logic                frame_clock_pin_oe_o
);

  clk_ctrl_type   ctrl;
  clk_ctrl_type   ctrl_q;
  clk_mode_type   next_mode;
  lock_state_type lock_state;
  logic [31:0]    lock_count;
  logic [31:0]    lock_target;
  logic           ever_locked;
  logic           fs_tick;
  logic [7:0]     phase;
  logic [7:0]     next_phase;
  logic           ref_ok;
  logic           rate_ok;
  logic           pll_restart;
  logic           bit_tap;
  logic           mclk_tap;

  // Reference code decode: frame, bit or master clock; others invalid.
  function automatic logic ref_code_valid(input logic [3:0] code);
    case (code)
      `REF_FRAME, `REF_BIT32, `REF_BIT64:       ref_code_valid = 1'b1;
      4'h4, 4'h5, 4'h6, 4'h7:                   ref_code_valid = 1'b1;
      `REF_MCLK_13M5, `REF_MCLK_27M:            ref_code_valid = 1'b1;
      default:                                  ref_code_valid = 1'b0;
    endcase
  endfunction

  // Decode whether a rate code is legal for the reference kind in use.
  function automatic logic rate_code_valid(input logic mclk_ref, input logic [3:0] rate);
    if (mclk_ref) begin
      case (rate)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: rate_code_valid = 1'b1;
        4'ha, 4'hb, 4'he, 4'hf:                         rate_code_valid = 1'b1;
        default:                                        rate_code_valid = 1'b0;
      endcase
    end else begin
      case ({rate[3], rate[1:0]})
        3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7: rate_code_valid = 1'b1;
        default:                            rate_code_valid = 1'b0;
      endcase
    end
  endfunction

  assign ctrl = ctrl_i;

  always_comb begin
    case ({ctrl.pll_power_bit, ctrl.master_select})
      2'b11:   next_mode = MODE_PLL_MASTER;
      2'b10:   next_mode = MODE_PLL_SLAVE;
      2'b00:   next_mode = MODE_EXTERNAL_SLAVE;
      default: next_mode = MODE_UNSUPPORTED;
    endcase
  end

  assign ref_ok  = ref_code_valid(ctrl.pll_ref_select);
  assign rate_ok = rate_code_valid(ctrl.pll_ref_select[`REF_KIND_BIT], ctrl.rate_select);

  // Lock time picked by the reference kind; bit clock uses the shortest lock time.
  always_comb begin
    if (ctrl.pll_ref_select[`REF_KIND_BIT]) begin
      lock_target = 32'(LOCK_MCLK_CYCLES);
    end else if (ctrl.pll_ref_select[1]) begin
      lock_target = 32'(LOCK_BIT_CYCLES);
    end else begin
      lock_target = 32'(LOCK_FRAME_CYCLES);
    end
  end

  // Control copy held in reset values while power-down is low.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= '{pll_power_bit: 1'b0, master_select: `MS_RESET,
                  pll_ref_select: `REF_RESET, rate_select: `RATE_RESET,
                  mclk_out_divider: `DIV_RESET, bitclk_ratio_select: `BCLK_RATIO_RESET,
                  mclk_out_enable: 1'b0};
    end else begin
      ctrl_q <= ctrl;
    end
  end

  // A power-up edge or a rate change restarts lock acquisition.
  assign pll_restart = (ctrl.pll_power_bit && !ctrl_q.pll_power_bit) ||
                       (ctrl.pll_power_bit && (ctrl.rate_select != ctrl_q.rate_select)) ||
                       (ctrl.pll_power_bit && (ctrl.pll_ref_select != ctrl_q.pll_ref_select));

  // Lock tracker: counts the lock time, then waits one frame to settle.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_state <= LOCK_OFF;
      lock_count <= '0;
    end else if (!ctrl.pll_power_bit || pll_restart) begin
      lock_state <= ctrl.pll_power_bit ? LOCK_WAIT : LOCK_OFF;
      lock_count <= '0;
    end else begin
      case (lock_state)
        LOCK_OFF: begin
          lock_state <= LOCK_WAIT;
          lock_count <= '0;
        end
        LOCK_WAIT: begin
          // Lock declared at the maximum lock time.
          if (lock_count + 32'h1 >= lock_target) begin
            lock_state <= LOCK_SETTLE;
          end
          lock_count <= lock_count + 32'h1;
        end
        LOCK_SETTLE: begin
          // One frame period before clocks count as regular.
          if (fs_tick && phase == 8'hff) begin
            lock_state <= LOCK_DONE;
          end
        end
        LOCK_DONE:   lock_state <= LOCK_DONE;
        default:     lock_state <= LOCK_OFF;
      endcase
    end
  end

  // Remember a first lock so a later unlock is known to be a loss, not a start.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ever_locked <= 1'b0;
    end else if (!ctrl.pll_power_bit || pll_restart) begin
      ever_locked <= 1'b0;
    end else if (lock_state == LOCK_SETTLE) begin
      ever_locked <= 1'b1;
    end
  end

  // The phase tick stands in for a 256 fs master clock; real rates come from the PLL.
  codec_clk_divider #(
    .WIDTH     (FS_DIV_WIDTH)
  ) u_fs_div (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .run_i     (lock_state == LOCK_SETTLE || lock_state == LOCK_DONE),
    .divisor_i (FS_DIV_WIDTH'(FS_DIVISOR)),
    .tick_o    (fs_tick)
  );

  assign next_phase = phase + 8'h1;

  // Phase counter: one wrap per frame, 256 ticks per sample.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase <= 8'h00;
    end else if (lock_state == LOCK_OFF || lock_state == LOCK_WAIT) begin
      phase <= 8'h00;
    end else if (fs_tick) begin
      phase <= next_phase;
    end
  end

  // Bit clock tap: 32 fs on bit 2, 64 fs on bit 1.
  assign bit_tap = ctrl.bitclk_ratio_select ? phase[1] : phase[2];

  // Master clock output tap per divider code.
  always_comb begin
    case (ctrl.mclk_out_divider)
      2'h0:    mclk_tap = fs_tick;
      2'h1:    mclk_tap = phase[0];
      2'h2:    mclk_tap = phase[1];
      2'h3:    mclk_tap = phase[2];
      default: mclk_tap = 1'b0;
    endcase
  end

  // Mode and status registers.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_mode_o       <= MODE_EXTERNAL_SLAVE;
      status_o         <= '0;
      pll_locked_o     <= 1'b0;
      clocks_regular_o <= 1'b0;
      mclk_in_used_o   <= 1'b1;
    end else begin
      clk_mode_o <= next_mode;
      status_o.ref_valid  <= ref_ok;
      status_o.rate_valid <= ctrl.pll_power_bit ? rate_ok : 1'b1;
      // External slave input ratio; bits 3-2 ignored, 00 and 10 alike.
      status_o.ext_mclk_ratio <= (ctrl.rate_select[1:0] == 2'h2) ? 2'h0
                                                                 : ctrl.rate_select[1:0];
      pll_locked_o     <= (lock_state == LOCK_SETTLE) || (lock_state == LOCK_DONE);
      clocks_regular_o <= (lock_state == LOCK_DONE);
      // Frame or bit reference leaves the master clock input unused.
      mclk_in_used_o <= !ctrl.pll_power_bit || ctrl.pll_ref_select[`REF_KIND_BIT];
    end
  end

  // Slave unlocked: converter data and enabled master clock output invalid.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_invalid_o     <= 1'b0;
      mclk_out_invalid_o <= 1'b0;
    end else begin
      data_invalid_o <= ctrl.pll_power_bit && (lock_state != LOCK_DONE);
      // Unsupported mode flags an enabled master clock output invalid.
      mclk_out_invalid_o <= ctrl.mclk_out_enable &&
                            ((next_mode == MODE_UNSUPPORTED) ||
                             (ctrl.pll_power_bit && lock_state != LOCK_DONE));
    end
  end

  // Master clock output low whenever its enable is clear.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mclk_out_o <= 1'b0;
    end else if (!ctrl.mclk_out_enable) begin
      mclk_out_o <= 1'b0;
    end else if (ctrl.pll_power_bit && ctrl.master_select) begin
      mclk_out_o <= mclk_tap;
    end else if (ctrl.pll_power_bit && ctrl.pll_ref_select[`REF_KIND_BIT]) begin
      mclk_out_o <= mclk_tap;
    end else begin
      mclk_out_o <= 1'b0;
    end
  end

  // Pins driven only while master select is one; otherwise left to pull resistors.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Reset leaves the device a slave with pins released.
      bit_clock_pin_oe_o   <= 1'b0;
      frame_clock_pin_oe_o <= 1'b0;
      bit_clock_pin_o      <= 1'b0;
      frame_clock_pin_o    <= 1'b0;
    end else if (!ctrl.master_select) begin
      // Slave until the host selects master.
      bit_clock_pin_oe_o   <= 1'b0;
      frame_clock_pin_oe_o <= 1'b0;
      bit_clock_pin_o      <= 1'b0;
      frame_clock_pin_o    <= 1'b0;
    end else begin
      bit_clock_pin_oe_o   <= 1'b1;
      frame_clock_pin_oe_o <= 1'b1;
      if (!ctrl.pll_power_bit || lock_state == LOCK_OFF || lock_state == LOCK_WAIT) begin
        bit_clock_pin_o   <= 1'b0;
        frame_clock_pin_o <= 1'b0;
      end else begin
        // Frame clock at fs, bit clock at chosen ratio.
        // Locked frame clock is exactly fs.
        bit_clock_pin_o   <= bit_tap;
        frame_clock_pin_o <= phase[7];
      end
    end
  end

endmodule

// ==== verif/codec_clk_chk.sv ====
// Purpose: Port-level checks for the codec clock mode control block.
// Assumes: One clock domain; lock counts equal those of the instance.
// Notes:   Lock bounds keep one cycle of slack below and four above for the registered decode.
`timescale 1ns/100ps
module codec_clk_chk
  import codec_clk_pkg::*;
#(
  parameter int LOCK_FRAME_CYCLES = 20,
  parameter int LOCK_BIT_CYCLES   = 10,
  parameter int LOCK_MCLK_CYCLES  = 15
) (
  input wire logic           clock_i,
  input wire logic           rst_b_i,
  input wire clk_ctrl_type   ctrl_i,
  input wire clk_mode_type   clk_mode_o,
  input wire clk_status_type status_o,
  input wire logic           pll_locked_o,
  input wire logic           mclk_out_invalid_o,
  input wire logic           mclk_out_o,
  input wire logic           bit_clock_pin_o,
  input wire logic           bit_clock_pin_oe_o,
  input wire logic           frame_clock_pin_o,
  input wire logic           frame_clock_pin_oe_o
);
  logic         warm;
  logic         was_locked;
  logic [15:0]  held;
  clk_ctrl_type last;
  int           target;

  // Warm marks edges whose previous sample lies after reset, so $past is trusted.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      warm <= 1'b0;
      last <= '0;
    end else begin
      warm <= 1'b1;
      last <= ctrl_i;
    end
  end

  // Held counts powered cycles since a reference or rate change restarted the lock.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      held <= '0;
      was_locked <= 1'b0;
    end else begin
      held <= (!ctrl_i.pll_power_bit || ctrl_i[11:4] != last[11:4]) ? 16'h0 : held + 16'h1;
      was_locked <= ctrl_i.pll_power_bit && (was_locked || pll_locked_o);
    end
  end

  // The lock time depends on which pin feeds the reference.
  assign target = ctrl_i.pll_ref_select[2] ? LOCK_MCLK_CYCLES :
                  (ctrl_i.pll_ref_select[3:1] == 3'h1 ? LOCK_BIT_CYCLES : LOCK_FRAME_CYCLES);

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  mode_decode_a: assert property (
    warm |-> clk_mode_o == {$past(ctrl_i.master_select), $past(ctrl_i.pll_power_bit)})
    else $error("clock mode wrong");
  pin_enable_a: assert property (
    warm |-> bit_clock_pin_oe_o == $past(ctrl_i.master_select) && frame_clock_pin_oe_o == bit_clock_pin_oe_o)
    else $error("clock pin enable wrong");
  mclk_quiet_a: assert property (
    (warm && !$past(ctrl_i.mclk_out_enable)) |-> !mclk_out_o)
    else $error("master clock output not low");
  unsup_invalid_a: assert property (
    (warm && clk_mode_o == MODE_UNSUPPORTED && $past(ctrl_i.mclk_out_enable)) |-> mclk_out_invalid_o)
    else $error("unsupported mode not flagged");
  pins_low_a: assert property (
    (clk_mode_o == MODE_PLL_MASTER && !was_locked && !pll_locked_o) |-> !bit_clock_pin_o && !frame_clock_pin_o)
    else $error("clock pins not low before lock");
  lock_early_a: assert property (
    $rose(pll_locked_o) |-> int'(held) >= target - 1)
    else $error("lock came too early");
  lock_late_a: assert property (
    (ctrl_i.pll_power_bit && status_o.ref_valid && status_o.rate_valid && int'(held) > target + 4)
    |-> pll_locked_o)
    else $error("lock came too late");
  lock_drop_a: assert property (
    (pll_locked_o && ctrl_i.pll_power_bit && $changed(ctrl_i.rate_select)) |-> ##[1:2] !pll_locked_o)
    else $error("lock kept after rate change");
endmodule

// ==== verif/codec_clk_partner.sv ====
// Purpose: Far-side audio processor that supplies slave clocks to the codec.
// Assumes: Pull-down resistors on both clock pins.
// Notes:   The supplied clocks stand still whenever supply_i is low.
`timescale 1ns/100ps
module codec_clk_partner (
  input  wire logic clock_i,
  input  wire logic supply_i,
  input  wire logic bit_pin_i,
  input  wire logic bit_oe_i,
  input  wire logic frame_pin_i,
  input  wire logic frame_oe_i,
  output logic      bit_line_o,
  output logic      frame_line_o
);
  logic [5:0] phase = 6'h0;

  // Supplied clock rates.
  // Bit clock toggles each cycle, frame every 32, giving 32 bit periods per frame.
  always_ff @(posedge clock_i) begin
    phase <= supply_i ? phase + 6'h1 : 6'h0;
  end

  // Slave inputs and pull-down.
  // The partner drives only while the codec does not, so the wire never fights.
  assign bit_line_o   = bit_oe_i ? bit_pin_i : (supply_i && phase[0]);
  assign frame_line_o = frame_oe_i ? frame_pin_i : (supply_i && phase[5]);
endmodule

// ==== verif/tb_codec_clock_mode_control.sv ====
// Purpose: Self-checking bench for the codec clock mode control block.
// Assumes: Short lock counts and a divisor of two keep the run brief.
// Notes:   Expected outputs travel through a queue to a separate monitor.
`timescale 1ns/100ps
module tb_codec_clock_mode_control;
  import codec_clk_pkg::*;
  localparam int LF = 20;
  localparam int LB = 10;
  localparam int LM = 15;
  logic           clock_i, rst_b_i, supply, bit_line, frame_line;
  clk_ctrl_type   ctrl_i, c;
  clk_mode_type   clk_mode_o;
  clk_status_type status_o;
  logic           pll_locked_o, clocks_regular_o, data_invalid_o, mclk_out_invalid_o;
  logic           mclk_in_used_o, mclk_out_o, bit_clock_pin_o, bit_clock_pin_oe_o;
  logic           frame_clock_pin_o, frame_clock_pin_oe_o;
  logic [2:0]     q, w;
  logic [17:0]    notes[$];
  logic [17:0]    n;
  int             mismatches, samples_checked, cnt[3], base[3], d[2][3];

  codec_clock_mode_control #(.LOCK_FRAME_CYCLES(LF), .LOCK_BIT_CYCLES(LB),
    .LOCK_MCLK_CYCLES(LM), .FS_DIV_WIDTH(16), .FS_DIVISOR(2)) uut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ctrl_i(ctrl_i), .clk_mode_o(clk_mode_o),
    .status_o(status_o), .pll_locked_o(pll_locked_o), .clocks_regular_o(clocks_regular_o),
    .data_invalid_o(data_invalid_o), .mclk_out_invalid_o(mclk_out_invalid_o),
    .mclk_in_used_o(mclk_in_used_o), .mclk_out_o(mclk_out_o),
    .bit_clock_pin_o(bit_clock_pin_o), .bit_clock_pin_oe_o(bit_clock_pin_oe_o),
    .frame_clock_pin_o(frame_clock_pin_o), .frame_clock_pin_oe_o(frame_clock_pin_oe_o));
  codec_clk_partner partner (.clock_i(clock_i), .supply_i(supply),
    .bit_pin_i(bit_clock_pin_o), .bit_oe_i(bit_clock_pin_oe_o), .frame_pin_i(frame_clock_pin_o),
    .frame_oe_i(frame_clock_pin_oe_o), .bit_line_o(bit_line), .frame_line_o(frame_line));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Rising edges of the master clock, bit and frame wires, for rate comparisons.
  assign w = {mclk_out_o, bit_line, frame_line};
  always @(posedge clock_i) begin
    q <= w;
    for (int j = 0; j < 3; j++) if (w[j] === 1'b1 && q[j] === 1'b0) cnt[j] <= cnt[j] + 1;
  end

  // Monitor: takes the oldest note and compares the masked outputs at mid-cycle.
  always @(negedge clock_i) begin
    if (notes.size() > 0) begin
      n = notes.pop_front();
      samples_checked++;
      if (({clk_mode_o, status_o, mclk_in_used_o, bit_clock_pin_oe_o, pll_locked_o} & n[17:9])
          !== (n[8:0] & n[17:9])) begin
        mismatches++;
        $display("unexpected at %0t: outputs differ from note %h", $time, n);
      end
    end
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_high(ref logic s, input int bound);
    for (int k = 0; k < bound && s !== 1'b1; k++) @(posedge clock_i);
    if (s !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: wait ran out", $time);
      results();
    end
  endtask

  // Drive one setting and note the decode expected one edge after it is taken.
  // Lock state is masked here; the lock scenarios check it on their own.
  task automatic apply(input clk_ctrl_type v);
    logic [8:0] e;
    logic [8:0] m;
    m = 9'h1fe;
    e[8:7] = {v.master_select, v.pll_power_bit};
    e[6] = v.pll_ref_select inside {4'h0, 4'h2, 4'h3, [4'h4:4'h7], 4'hc, 4'hd};
    e[5] = !v.pll_power_bit || (v.pll_ref_select[2] ? !(v.rate_select inside
           {4'h8, 4'h9, 4'hc, 4'hd}) : (!v.rate_select[3] || v.rate_select[1]));
    e[4:3] = (v.rate_select[1:0] == 2'h2) ? 2'h0 : v.rate_select[1:0];
    e[2] = !(v.pll_power_bit && !v.pll_ref_select[2]);
    e[1:0] = {v.master_select, 1'b0};
    if (v.pll_power_bit || v.master_select) m[4:3] = 2'h0;
    if (!v.pll_power_bit) m[6] = 1'b0;
    @(posedge clock_i);
    ctrl_i <= v;
    @(posedge clock_i);
    notes.push_back({m, e});
  endtask

  task automatic lock_test(input logic [3:0] f, input logic mst, input int tgt);
    apply('0);
    c = '{1'b1, mst, f, f[2] ? 4'hb : 4'h7, 2'($urandom), 1'($urandom), 1'($urandom)};
    supply <= ~mst;
    // Host mute of the playback paths lies outside this block.
    apply(c);
    repeat (tgt - 3) @(posedge clock_i);
    notes.push_back({9'h001, 9'h000});
    chk(data_invalid_o === 1'b1, "data valid before lock");
    wait_high(pll_locked_o, 12);
    $display("test lock with reference %h done", f);
  endtask

  initial begin
    rst_b_i = 1'b0;
    ctrl_i = '0;
    supply = 1'b0;
    cnt = '{0, 0, 0};
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'h5395aa90));
    repeat (5) @(posedge clock_i);
    notes.push_back({9'h1ff, 9'h004});
    chk(bit_line === 1'b0 && frame_line === 1'b0, "idle pins not low");
    rst_b_i <= 1'b1;
    // Host starts as slave and sets the master bit only later.
    for (int i = 0; i < 4; i++) begin
      c = '{i[0], i[1], 4'h4, 4'h0, 2'($urandom), 1'($urandom), 1'($urandom) | (i == 2)};
      apply(c);
    end
    $display("test mode decode done");
    for (int r = 0; r < 16; r++) begin
      apply('{1'b1, 1'b0, 4'(r), 4'h0, 2'h0, 1'b0, 1'b0});
      apply('{1'b1, 1'b0, 4'h5, 4'(r), 2'h0, 1'b0, 1'b0});
      apply('{1'b1, 1'b0, 4'h2, 4'(r), 2'h0, 1'b0, 1'b0});
      apply('{1'b0, 1'b0, 4'h2, 4'(r), 2'h0, 1'b0, 1'b0});
    end
    $display("test code tables done");
    lock_test(4'h0, 1'b0, LF);
    lock_test(4'h2, 1'b0, LB);
    lock_test(4'h4, 1'b1, LM);
    wait_high(clocks_regular_o, 600);
    for (int k = 0; k < 2; k++) begin
      c = '{1'b1, 1'b1, 4'h4, 4'hb, k[0] ? 2'h3 : 2'h0, k[0], 1'b1};
      apply(c);
      base = cnt;
      repeat (3000) @(posedge clock_i);
      for (int j = 0; j < 3; j++) d[k][j] = cnt[j] - base[j];
    end
    chk(d[0][2] > d[1][2] && d[1][2] > 0, "divider ratio wrong");
    chk(d[1][1] > d[0][1], "bit clock ratio wrong");
    chk(d[0][0] > 1 && d[0][1] > d[0][0], "frame or bit clock missing");
    c.mclk_out_enable = 1'b0;
    apply(c);
    base = cnt;
    repeat (50) @(posedge clock_i);
    chk(cnt[2] == base[2], "master clock output toggles when disabled");
    $display("test master clocks done");
    c.rate_select = 4'ha;
    apply(c);
    @(posedge clock_i);
    notes.push_back({9'h001, 9'h000});
    c.pll_power_bit = 1'b0;
    apply(c);
    repeat (2) @(posedge clock_i);
    chk(bit_line === 1'b0 && frame_line === 1'b0, "clocks not low after power clear");
    rst_b_i <= 1'b0;
    @(posedge clock_i);
    notes.push_back({9'h1ff, 9'h004});
    @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    $display("test second reset done");
    results();
  end
endmodule

bind codec_clock_mode_control codec_clk_chk #(.LOCK_FRAME_CYCLES(LOCK_FRAME_CYCLES),
  .LOCK_BIT_CYCLES(LOCK_BIT_CYCLES), .LOCK_MCLK_CYCLES(LOCK_MCLK_CYCLES)) chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .ctrl_i(ctrl_i), .clk_mode_o(clk_mode_o),
  .status_o(status_o), .pll_locked_o(pll_locked_o), .mclk_out_invalid_o(mclk_out_invalid_o),
  .mclk_out_o(mclk_out_o), .bit_clock_pin_o(bit_clock_pin_o),
  .bit_clock_pin_oe_o(bit_clock_pin_oe_o), .frame_clock_pin_o(frame_clock_pin_o),
  .frame_clock_pin_oe_o(frame_clock_pin_oe_o));
